// file: design/nv_image_mem.sv
`timescale 1ns/1ps
// Non-volatile image store; the array has no reset so it survives a drive reset.
module nv_image_mem #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = 8
) (
	// Clock.
	input  wire logic                     clock_i,
	// Write and read port.
	input  wire logic                     we_i,
	input  wire logic [$clog2(DEPTH)-1:0] addr_i,
	input  wire logic [WIDTH-1:0]         wdata_i,
	output logic      [WIDTH-1:0]         rdata_o
);
	logic [WIDTH-1:0] cells [DEPTH];

	// Write cells and register the read word.
	always_ff @(posedge clock_i) begin
		if (we_i) begin
			cells[addr_i] <= wdata_i;
		end
		rdata_o <= cells[addr_i];
	end
endmodule

// file: design/position_retention_ctrl.sv
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - Select accepts 1, 2, 11, 12; 9999 (reset value) disables retention.
// - On servo-on falling, chosen position data and home-done flag are held.
// - Settings 2 and 12 keep command, current position and droop unchanged.
// - Settings 1 and 11 keep current position, clear droop, align command.
// - Settings 1 and 2 are volatile; 9999 clears all and drops home-done.
// - Settings 11 and 12 store data and flag in EEPROM across resets.
// - Select, gear, capacitor measurement or motor swap changes clear held data.
// - Control method change, protective trip or unavailability clear held data.
// - EEPROM write completes about one second after servo-on falls.
// - An interrupted write raises the position fault trip at next power-up.
// - Only signed 32-bit position values may be stored in EEPROM.
// - Out of span values skip the store and erase the old image.
// - Methods 4, 5 force inactive mode switch until link up; may clear data.
module position_retention_ctrl #(
	parameter int unsigned POS_W        = retention_pkg::POS_W,
	parameter int unsigned WRITE_CYCLES = retention_pkg::EE_WRITE_CYCLES
) (
	// Clock and reset.
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	// APB slave.
	input  wire logic             psel_i,
	input  wire logic             penable_i,
	input  wire logic             pwrite_i,
	input  wire logic [7:0]       paddr_i,
	input  wire logic [31:0]      pwdata_i,
	output logic      [31:0]      prdata_o,
	output logic                  pready_o,
	output logic                  pslverr_o,
	// Live loop state and drive events.
	input  wire logic             servo_on_input_i,
	input  wire logic             home_done_i,
	input  wire logic [POS_W-1:0] pos_cmd_i,
	input  wire logic [POS_W-1:0] cur_pos_i,
	input  wire logic [POS_W-1:0] droop_i,
	input  wire logic             cap_life_meas_i,
	input  wire logic             trip_i,
	input  wire logic             retention_unavail_i,
	input  wire logic             mode_switch_input_i,
	input  wire logic             link_up_i,
	// Held state and status.
	output logic [POS_W-1:0]      hold_cmd_o,
	output logic [POS_W-1:0]      hold_cur_o,
	output logic [POS_W-1:0]      hold_droop_o,
	output logic                  hold_valid_o,
	output logic                  home_done_flag_o,
	output logic                  ee_busy_o,
	output logic                  position_fault_trip_o,
	output logic                  mode_eff_o,
	output logic                  irq_o
);
	localparam int unsigned CW = $clog2(WRITE_CYCLES + 1);

	logic [13:0]               retention_select;
	logic [31:0]               gear_numerator;
	logic [31:0]               gear_denominator;
	logic [2:0]                control_method_select;
	logic                      motor2_sel;
	logic [retention_pkg::STAT_W-1:0] status;
	logic [retention_pkg::STAT_W-1:0] irq_mask;
	retention_pkg::seq_state_e state;
	logic [2:0]                idx;
	logic [CW-1:0]             wait_cnt;
	logic                      servo_q;
	logic                      pend_erase;
	logic                      mem_we;
	logic [2:0]                mem_addr;
	logic [31:0]               mem_wdata;
	logic [31:0]               mem_rdata;
	logic                      wr_acc;
	logic                      rd_done;
	logic                      sel_legal;
	logic                      clr_sel;
	logic                      clr_gear;
	logic                      clr_cfg;
	logic                      clr_mode;
	logic                      clr_any;
	logic                      servo_fall;
	logic                      sel_nv;
	logic                      sel_cur;
	logic                      sel_keep;
	logic                      in_span;
	logic                      next_mode_eff;
	logic [31:0]               next_rdata;
	logic                      boot_busy;
	logic                      boot_done;

	// Signed 32-bit span check on a live position value.
	function automatic logic fits32(input logic [POS_W-1:0] v);
		fits32 = (&v[POS_W-1:31]) | ~(|v[POS_W-1:31]);
	endfunction

	// Bus decode and write side effects.
	assign wr_acc    = psel_i & penable_i & pready_o & pwrite_i;
	assign rd_done   = psel_i & penable_i & pready_o & ~pwrite_i
		& (paddr_i == retention_pkg::ADDR_STATUS);
	assign sel_legal = (pwdata_i[13:0] == retention_pkg::SEL_OFF)
		| (pwdata_i[13:0] == retention_pkg::SEL_VOL_CUR)
		| (pwdata_i[13:0] == retention_pkg::SEL_VOL_ALL)
		| (pwdata_i[13:0] == retention_pkg::SEL_NV_CUR) | (pwdata_i[13:0] == retention_pkg::SEL_NV_ALL);
	assign clr_sel   = wr_acc & (paddr_i == retention_pkg::ADDR_SELECT) & sel_legal
		& (pwdata_i[13:0] != retention_select);
	assign clr_gear  = wr_acc & (((paddr_i == retention_pkg::ADDR_GEAR_N) & (pwdata_i != gear_numerator))
		| ((paddr_i == retention_pkg::ADDR_GEAR_D) & (pwdata_i != gear_denominator)));
	assign clr_cfg   = wr_acc & (paddr_i == retention_pkg::ADDR_CONFIG)
		& ((pwdata_i[retention_pkg::CFG_CM_LSB +: 3] != control_method_select)
		| (pwdata_i[retention_pkg::CFG_MOTOR2] != motor2_sel));
	assign clr_mode  = next_mode_eff != mode_eff_o;
	assign clr_any   = clr_sel | clr_gear | clr_cfg | clr_mode | cap_life_meas_i | trip_i
		| retention_unavail_i;

	// Servo-on edge and what the select asks for.
	assign servo_fall = servo_q & ~servo_on_input_i;
	assign sel_nv     = (retention_select == retention_pkg::SEL_NV_CUR)
		| (retention_select == retention_pkg::SEL_NV_ALL);
	assign sel_cur    = (retention_select == retention_pkg::SEL_VOL_CUR)
		| (retention_select == retention_pkg::SEL_NV_CUR);
	assign sel_keep   = sel_cur | (retention_select == retention_pkg::SEL_VOL_ALL)
		| (retention_select == retention_pkg::SEL_NV_ALL);
	assign in_span    = fits32(pos_cmd_i) & fits32(cur_pos_i) & fits32(droop_i);

	// Under methods 4 and 5 the mode switch reads inactive until the link is up.
	always_comb begin
		next_mode_eff = mode_switch_input_i;
		if (((control_method_select == retention_pkg::CM_SPD_POS)
			| (control_method_select == retention_pkg::CM_POS_TRQ)) & ~link_up_i) begin
			next_mode_eff = 1'b0;
		end
	end

	// Configuration registers; illegal select values are ignored.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			retention_select      <= retention_pkg::SEL_OFF;
			gear_numerator        <= retention_pkg::GEAR_RST;
			gear_denominator      <= retention_pkg::GEAR_RST;
			control_method_select <= retention_pkg::CM_RESET;
			motor2_sel            <= 1'b0;
			irq_mask              <= '0;
		end else if (wr_acc) begin
			case (paddr_i)
				retention_pkg::ADDR_SELECT: begin
					if (sel_legal) begin
						retention_select <= pwdata_i[13:0];
					end
				end
				retention_pkg::ADDR_GEAR_N: gear_numerator <= pwdata_i;
				retention_pkg::ADDR_GEAR_D: gear_denominator <= pwdata_i;
				retention_pkg::ADDR_CONFIG: begin
					control_method_select <= pwdata_i[retention_pkg::CFG_CM_LSB +: 3];
					motor2_sel            <= pwdata_i[retention_pkg::CFG_MOTOR2];
				end
				retention_pkg::ADDR_MASK: irq_mask <= pwdata_i[retention_pkg::STAT_W-1:0];
				default: ;
			endcase
		end
	end

	// Read mux for the access phase.
	always_comb begin
		next_rdata = '0;
		case (paddr_i)
			retention_pkg::ADDR_SELECT: next_rdata = {18'h0, retention_select};
			retention_pkg::ADDR_GEAR_N: next_rdata = gear_numerator;
			retention_pkg::ADDR_GEAR_D: next_rdata = gear_denominator;
			retention_pkg::ADDR_CONFIG: next_rdata = {27'h0, motor2_sel, 1'b0, control_method_select};
			retention_pkg::ADDR_STATUS: next_rdata = {28'h0, status};
			retention_pkg::ADDR_MASK:   next_rdata = {28'h0, irq_mask};
			retention_pkg::ADDR_STATE:  next_rdata = {27'h0, position_fault_trip_o, ee_busy_o,
				home_done_flag_o, hold_valid_o, mode_eff_o};
			retention_pkg::ADDR_CMD:    next_rdata = hold_cmd_o[31:0];
			retention_pkg::ADDR_CUR:    next_rdata = hold_cur_o[31:0];
			retention_pkg::ADDR_DROOP:  next_rdata = hold_droop_o[31:0];
			default:                    next_rdata = '0;
		endcase
	end

	// One wait state: answer is registered in the first access cycle.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= '0;
		end else begin
			pready_o  <= psel_i & penable_i & ~pready_o;
			pslverr_o <= psel_i & penable_i & ~pready_o & (paddr_i > retention_pkg::ADDR_DROOP);
			prdata_o  <= (psel_i & penable_i & ~pready_o & ~pwrite_i) ? next_rdata : '0;
		end
	end

	// Sticky status; a read clears only the bits it reported, so a new event wins.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			status <= '0;
			irq_o  <= 1'b0;
		end else begin
			status <= (status & ~(rd_done ? prdata_o[retention_pkg::STAT_W-1:0] : '0))
				| {boot_busy,
				clr_any, servo_fall & sel_nv & ~in_span & ~clr_any,
				state == retention_pkg::S_WR_MARK};
			irq_o  <= |(status & irq_mask);
		end
	end

	// Edge tracking and the forced mode view.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			servo_q    <= 1'b0;
			mode_eff_o <= 1'b0;
		end else begin
			servo_q    <= servo_on_input_i;
			mode_eff_o <= next_mode_eff;
		end
	end

	// Held position data and home-done flag; clear events take priority.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			hold_cmd_o       <= '0;
			hold_cur_o       <= '0;
			hold_droop_o     <= '0;
			hold_valid_o     <= 1'b0;
			home_done_flag_o <= 1'b0;
		end else if (clr_any) begin
			hold_cmd_o       <= '0;
			hold_cur_o       <= '0;
			hold_droop_o     <= '0;
			hold_valid_o     <= 1'b0;
			home_done_flag_o <= 1'b0;
		end else if (state == retention_pkg::S_BOOT_TAKE) begin
			case (idx)
				retention_pkg::NV_CMD:   hold_cmd_o <= POS_W'($signed(mem_rdata));
				retention_pkg::NV_CUR:   hold_cur_o <= POS_W'($signed(mem_rdata));
				retention_pkg::NV_DROOP: hold_droop_o <= POS_W'($signed(mem_rdata));
				retention_pkg::NV_HOME: begin
					home_done_flag_o <= mem_rdata[0];
					hold_valid_o     <= 1'b1;
				end
				default: ;
			endcase
		end else if (servo_fall) begin
			if (sel_keep) begin
				hold_cur_o       <= cur_pos_i;
				hold_cmd_o       <= sel_cur ? cur_pos_i : pos_cmd_i;
				hold_droop_o     <= sel_cur ? '0 : droop_i;
				hold_valid_o     <= 1'b1;
				home_done_flag_o <= home_done_i;
			end else begin
				hold_cmd_o       <= '0;
				hold_cur_o       <= '0;
				hold_droop_o     <= '0;
				hold_valid_o     <= 1'b0;
				home_done_flag_o <= 1'b0;
			end
		end else if (servo_on_input_i) begin
			home_done_flag_o <= home_done_i;
		end
	end

	// EEPROM port follows the sequencer state.
	always_comb begin
		mem_we    = 1'b0;
		mem_addr  = idx;
		mem_wdata = retention_pkg::MARK_EMPTY;
		case (state)
			retention_pkg::S_BOOT: mem_addr = retention_pkg::NV_MARK;
			retention_pkg::S_WR_DATA: begin
				mem_we = 1'b1;
				case (idx)
					retention_pkg::NV_MARK:  mem_wdata = retention_pkg::MARK_BUSY;
					retention_pkg::NV_CMD:   mem_wdata = hold_cmd_o[31:0];
					retention_pkg::NV_CUR:   mem_wdata = hold_cur_o[31:0];
					retention_pkg::NV_DROOP: mem_wdata = hold_droop_o[31:0];
					default:                 mem_wdata = {31'h0, home_done_flag_o};
				endcase
			end
			retention_pkg::S_WR_MARK: begin
				mem_we    = 1'b1;
				mem_addr  = retention_pkg::NV_MARK;
				mem_wdata = retention_pkg::MARK_DONE;
			end
			retention_pkg::S_IDLE: begin
				mem_we   = pend_erase;
				mem_addr = retention_pkg::NV_MARK;
			end
			default: ;
		endcase
	end

	nv_image_mem #(
		.WIDTH (retention_pkg::WORD_W),
		.DEPTH (retention_pkg::NV_DEPTH)
	) u_image (
		.clock_i (clock_i),
		.we_i    (mem_we),
		.addr_i  (mem_addr),
		.wdata_i (mem_wdata),
		.rdata_o (mem_rdata)
	);

	// Boot marker decode; a part that was never written counts as blank.
	always_comb begin
		boot_busy = 1'b0;
		boot_done = 1'b0;
		if (state == retention_pkg::S_BOOT_CHK) begin
			if (mem_rdata == retention_pkg::MARK_BUSY) begin
				boot_busy = 1'b1;
			end
			if (mem_rdata == retention_pkg::MARK_DONE) begin
				boot_done = 1'b1;
			end
		end
	end

	// Restore after reset, then the timed store after servo-on falls.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state    <= retention_pkg::S_BOOT;
			idx      <= retention_pkg::NV_MARK;
			wait_cnt <= '0;
		end else begin
			case (state)
				retention_pkg::S_BOOT: state <= retention_pkg::S_BOOT_CHK;
				retention_pkg::S_BOOT_CHK: begin
					idx   <= retention_pkg::NV_CMD;
					state <= boot_done ? retention_pkg::S_BOOT_LOAD : retention_pkg::S_IDLE;
				end
				retention_pkg::S_BOOT_LOAD: state <= retention_pkg::S_BOOT_TAKE;
				retention_pkg::S_BOOT_TAKE: begin
					idx   <= idx + 3'h1;
					state <= (idx == retention_pkg::NV_HOME) ? retention_pkg::S_IDLE
						: retention_pkg::S_BOOT_LOAD;
				end
				retention_pkg::S_IDLE: begin
					idx <= retention_pkg::NV_MARK;
					if (servo_fall & sel_nv & in_span & ~clr_any & ~pend_erase) begin
						state <= retention_pkg::S_WR_DATA;
					end
				end
				retention_pkg::S_WR_DATA: begin
					idx <= idx + 3'h1;
					if (idx == retention_pkg::NV_HOME) begin
						wait_cnt <= CW'(WRITE_CYCLES);
						state    <= retention_pkg::S_WR_WAIT;
					end
				end
				retention_pkg::S_WR_WAIT: begin
					wait_cnt <= wait_cnt - CW'(1);
					if (wait_cnt <= CW'(1)) begin
						state <= retention_pkg::S_WR_MARK;
					end
				end
				retention_pkg::S_WR_MARK: state <= retention_pkg::S_IDLE;
				default: state <= retention_pkg::S_IDLE;
			endcase
		end
	end

	// Erase request: interrupted image, skipped store, clear event or shutoff with retention off.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pend_erase <= 1'b0;
		end else if (clr_any | (servo_fall & sel_nv & ~in_span) | boot_busy) begin
			pend_erase <= 1'b1;
		end else if (servo_fall & ~sel_keep) begin
			pend_erase <= 1'b1;
		end else if (state == retention_pkg::S_IDLE) begin
			pend_erase <= 1'b0;
		end
	end

	// Busy flag and the power-up fault latch.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ee_busy_o             <= 1'b0;
			position_fault_trip_o <= 1'b0;
		end else begin
			ee_busy_o <= (state == retention_pkg::S_WR_DATA) | (state == retention_pkg::S_WR_WAIT)
				| ((state == retention_pkg::S_IDLE) & servo_fall & sel_nv & in_span & ~clr_any
				& ~pend_erase);
			if (boot_busy) begin
				position_fault_trip_o <= 1'b1;
			end
		end
	end

	// Checks.
	a_select_legal: assert property (@(posedge clock_i) disable iff (rst_i)
		(retention_select == retention_pkg::SEL_OFF) | (retention_select == retention_pkg::SEL_VOL_CUR)
		| (retention_select == retention_pkg::SEL_VOL_ALL)
		| (retention_select == retention_pkg::SEL_NV_CUR)
		| (retention_select == retention_pkg::SEL_NV_ALL)) else $error("Illegal retention select.");
	a_hold_home_flag: assert property (@(posedge clock_i) disable iff (rst_i)
		servo_fall & sel_keep & ~clr_any & (state != retention_pkg::S_BOOT_TAKE)
		|=> hold_valid_o && home_done_flag_o == $past(home_done_i)) else $error("Flag not held.");
	a_keep_all: assert property (@(posedge clock_i) disable iff (rst_i)
		servo_fall & sel_keep & ~sel_cur & ~clr_any & (state != retention_pkg::S_BOOT_TAKE)
		|=> hold_cmd_o == $past(pos_cmd_i) && hold_droop_o == $past(droop_i))
		else $error("Data not kept.");
	a_cur_align: assert property (@(posedge clock_i) disable iff (rst_i)
		servo_fall & sel_cur & ~clr_any & (state != retention_pkg::S_BOOT_TAKE)
		|=> hold_cmd_o == hold_cur_o && hold_droop_o == '0) else $error("Command not aligned.");
	a_off_clears: assert property (@(posedge clock_i) disable iff (rst_i)
		servo_fall & (retention_select == retention_pkg::SEL_OFF)
		|=> !hold_valid_o && !home_done_flag_o) else $error("Disabled select kept data.");
	a_event_clears: assert property (@(posedge clock_i) disable iff (rst_i)
		clr_any |=> !hold_valid_o && hold_cur_o == '0 && !home_done_flag_o)
		else $error("Data not cleared.");
	a_store_starts: assert property (@(posedge clock_i) disable iff (rst_i)
		(state == retention_pkg::S_IDLE) & servo_fall & sel_nv & in_span & ~clr_any & ~pend_erase
		|=> ee_busy_o ##1 ee_busy_o [*4] ##1 state == retention_pkg::S_WR_WAIT) else $error("No store.");
	a_busy_held: assert property (@(posedge clock_i) disable iff (rst_i)
		(state == retention_pkg::S_WR_WAIT) |-> ##1 ee_busy_o || state == retention_pkg::S_WR_MARK)
		else $error("Busy dropped early.");
	a_range_skip: assert property (@(posedge clock_i) disable iff (rst_i)
		servo_fall & sel_nv & ~in_span |=> pend_erase && state != retention_pkg::S_WR_DATA)
		else $error("Out of span value stored.");
	a_boot_fault: assert property (@(posedge clock_i) disable iff (rst_i)
		(state == retention_pkg::S_BOOT_CHK) & (mem_rdata == retention_pkg::MARK_BUSY)
		|=> position_fault_trip_o && mem_we) else $error("Interrupted image not flagged.");
	a_mode_forced: assert property (@(posedge clock_i) disable iff (rst_i)
		(control_method_select == retention_pkg::CM_SPD_POS) & ~link_up_i & $stable(control_method_select)
		|=> !mode_eff_o) else $error("Mode switch not forced.");
	c_nv_store: cover property (@(posedge clock_i) disable iff (rst_i)
		state == retention_pkg::S_WR_MARK);
	c_restore: cover property (@(posedge clock_i) disable iff (rst_i)
		state == retention_pkg::S_BOOT_TAKE && idx == retention_pkg::NV_HOME);
	c_vol_hold: cover property (@(posedge clock_i) disable iff (rst_i)
		servo_fall && retention_select == retention_pkg::SEL_VOL_CUR);
endmodule

// file: design/retention_pkg.sv
package retention_pkg;

	// Clock rate and the EEPROM write window.
	localparam int unsigned CLK_FREQ_HZ      = 100_000_000;
	localparam int unsigned EE_WRITE_TIME_MS = 1000;
	localparam int unsigned EE_WRITE_CYCLES  = EE_WRITE_TIME_MS * (CLK_FREQ_HZ / 1000);

	// Live position width inside the loop and the storable word width.
	localparam int unsigned POS_W  = 40;
	localparam int unsigned WORD_W = 32;

	// Retention select values.
	localparam logic [13:0] SEL_OFF     = 14'h270f;
	localparam logic [13:0] SEL_VOL_CUR = 14'h0001;
	localparam logic [13:0] SEL_VOL_ALL = 14'h0002;
	localparam logic [13:0] SEL_NV_CUR  = 14'h000b;
	localparam logic [13:0] SEL_NV_ALL  = 14'h000c;

	// Control method codes of interest.
	localparam logic [2:0] CM_LINK    = 3'h3;
	localparam logic [2:0] CM_SPD_POS = 3'h4;
	localparam logic [2:0] CM_POS_TRQ = 3'h5;
	localparam logic [2:0] CM_RESET   = 3'h0;

	// Register byte addresses.
	localparam logic [7:0] ADDR_SELECT = 8'h00;
	localparam logic [7:0] ADDR_GEAR_N = 8'h04;
	localparam logic [7:0] ADDR_GEAR_D = 8'h08;
	localparam logic [7:0] ADDR_CONFIG = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_MASK   = 8'h14;
	localparam logic [7:0] ADDR_STATE  = 8'h18;
	localparam logic [7:0] ADDR_CMD    = 8'h1c;
	localparam logic [7:0] ADDR_CUR    = 8'h20;
	localparam logic [7:0] ADDR_DROOP  = 8'h24;

	// Config fields: control method in bits 2:0, second motor in bit 4.
	localparam int unsigned CFG_CM_LSB = 0;
	localparam int unsigned CFG_MOTOR2 = 4;
	localparam logic [31:0] GEAR_RST   = 32'h0000_0001;

	// Sticky status bits.
	localparam int unsigned STAT_W          = 4;
	localparam int unsigned ST_WRITE_DONE   = 0;
	localparam int unsigned ST_RANGE_SKIP   = 1;
	localparam int unsigned ST_DATA_CLEARED = 2;
	localparam int unsigned ST_FAULT        = 3;

	// EEPROM image layout and markers.
	localparam int unsigned NV_DEPTH = 8;
	localparam logic [2:0] NV_MARK  = 3'h0;
	localparam logic [2:0] NV_CMD   = 3'h1;
	localparam logic [2:0] NV_CUR   = 3'h2;
	localparam logic [2:0] NV_DROOP = 3'h3;
	localparam logic [2:0] NV_HOME  = 3'h4;
	localparam logic [31:0] MARK_EMPTY = 32'h0000_0000;
	localparam logic [31:0] MARK_BUSY  = 32'h0000_00b5;
	localparam logic [31:0] MARK_DONE  = 32'h0000_005a;

	// Sequencer states.
	typedef enum logic [2:0] {
		S_BOOT, S_BOOT_CHK, S_BOOT_LOAD, S_BOOT_TAKE,
		S_IDLE, S_WR_DATA, S_WR_WAIT, S_WR_MARK
	} seq_state_e;

endpackage

// file: dv/position_retention_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin num_errors++; \
	$display("Error %s expected %h seen %h", n, e, s); end end
module position_retention_ctrl_tb;
	typedef struct {logic [13:0] sel; logic [39:0] cmd, cur, droop; logic nv;} row_s;
	logic        clock_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
	logic        rst_req = 1'b0, rst_force = 1'b1, home = 1'b1, cap = 1'b0, trip = 1'b0;
	logic        servo, rst, pready, perr, err, busy, fault, irq, valid, hflag, meff;
	logic        msw = 1'b0, lnk = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [39:0] cmd = 40'h10, cur = 40'h20, droop = 40'h5, h_cmd, h_cur, h_droop;
	int          num_errors = 0, check_count = 0, cyc = 0;
	row_s        rows [5] = '{
		'{retention_pkg::SEL_VOL_CUR, 40'h20, 40'h20, 40'h0, 1'b0},
		'{retention_pkg::SEL_VOL_ALL, 40'h10, 40'h20, 40'h5, 1'b0},
		'{retention_pkg::SEL_NV_CUR, 40'h20, 40'h20, 40'h0, 1'b1},
		'{retention_pkg::SEL_NV_ALL, 40'h10, 40'h20, 40'h5, 1'b1},
		'{retention_pkg::SEL_OFF, 40'h0, 40'h0, 40'h0, 1'b0}};
	servo_ctrl_model u_servo_ctrl_model (.clock_i(clock_i), .run_i(run), .stopped_i(1'b1),
		.rst_req_i(rst_req), .rst_force_i(rst_force), .ee_busy_i(busy), .servo_on_o(servo),
		.rst_o(rst));
	position_retention_ctrl #(.WRITE_CYCLES(20)) u_position_retention_ctrl (.clock_i(clock_i),
		.rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
		.servo_on_input_i(servo), .home_done_i(home), .pos_cmd_i(cmd), .cur_pos_i(cur),
		.droop_i(droop), .cap_life_meas_i(cap), .trip_i(trip), .retention_unavail_i(1'b0),
		.mode_switch_input_i(msw), .link_up_i(lnk), .hold_cmd_o(h_cmd), .hold_cur_o(h_cur),
		.hold_droop_o(h_droop), .hold_valid_o(valid), .home_done_flag_o(hflag),
		.ee_busy_o(busy), .position_fault_trip_o(fault), .mode_eff_o(meff), .irq_o(irq));
	// Free-running 100 MHz clock.
	initial forever #5 clock_i = ~clock_i;
	// Hang guard.
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			close_out();
		end
	end
	// One APB transfer; read data and error are taken at the ready edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		do @(posedge clock_i); while (pready !== 1'b1);
		rd = prdata;
		err = perr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock_i);
	endtask
	// Run then shut off the servo.
	task automatic shutoff();
		run <= 1'b1;
		repeat (3) @(posedge clock_i);
		run <= 1'b0;
		repeat (5) @(posedge clock_i);
	endtask
	// Reset for five cycles, then let the restore finish.
	task automatic do_reset(input logic f);
		rst_req <= ~f;
		rst_force <= f;
		repeat (5) @(posedge clock_i);
		rst_req <= 1'b0;
		rst_force <= 1'b0;
		repeat (14) @(posedge clock_i);
	endtask
	// Final report and verdict.
	task automatic close_out();
		$display("Checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Main sequence: row loop, then hand-written cases.
	initial begin
		do_reset(1'b1);
		apb(1'b1, retention_pkg::ADDR_SELECT, 32'h5);
		apb(1'b0, retention_pkg::ADDR_SELECT, 32'h0);
		`CHK("select", 32'h270f, rd)
		foreach (rows[i]) begin
			apb(1'b1, retention_pkg::ADDR_SELECT, 32'(rows[i].sel));
			shutoff();
			`CHK("cmd", rows[i].cmd, h_cmd)
			`CHK("cur", rows[i].cur, h_cur)
			`CHK("droop", rows[i].droop, h_droop)
			`CHK("home", rows[i].cur != 40'h0, hflag)
			`CHK("valid", rows[i].sel != retention_pkg::SEL_OFF, valid)
			repeat (40) @(posedge clock_i);
			apb(1'b0, retention_pkg::ADDR_STATUS, 32'h0);
			`CHK("written", rows[i].nv, rd[0])
			do_reset(1'b0);
			`CHK("kept", rows[i].nv ? rows[i].cur : 40'h0, h_cur)
		end
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, retention_pkg::ADDR_SELECT, 32'(retention_pkg::SEL_VOL_ALL));
			shutoff();
			cap <= (k == 0);
			trip <= (k == 1);
			@(posedge clock_i);
			cap <= 1'b0;
			trip <= 1'b0;
			repeat (2) @(posedge clock_i);
			`CHK("cleared", 40'h0, h_cur)
		end
		apb(1'b1, retention_pkg::ADDR_SELECT, 32'(retention_pkg::SEL_NV_ALL));
		apb(1'b1, retention_pkg::ADDR_MASK, 32'hf);
		apb(1'b0, retention_pkg::ADDR_STATUS, 32'h0);
		cur <= 40'h01_0000_0000;
		shutoff();
		`CHK("nostore", 1'b0, busy)
		`CHK("irq", 1'b1, irq)
		apb(1'b0, retention_pkg::ADDR_STATUS, 32'h0);
		`CHK("skip", 1'b1, rd[1])
		@(posedge clock_i);
		`CHK("irqclr", 1'b0, irq)
		cur <= 40'h20;
		apb(1'b1, retention_pkg::ADDR_SELECT, 32'(retention_pkg::SEL_NV_CUR));
		shutoff();
		`CHK("busy", 1'b1, busy)
		do_reset(1'b1);
		`CHK("fault", 1'b1, fault)
		apb(1'b1, retention_pkg::ADDR_CONFIG, 32'(retention_pkg::CM_SPD_POS));
		apb(1'b1, retention_pkg::ADDR_SELECT, 32'(retention_pkg::SEL_VOL_ALL));
		msw <= 1'b1;
		shutoff();
		`CHK("forced", 1'b0, meff)
		lnk <= 1'b1;
		repeat (2) @(posedge clock_i);
		`CHK("modeclr", 40'h0, h_cur)
		`CHK("mode", 1'b1, meff)
		apb(1'b1, retention_pkg::ADDR_CONFIG, 32'(retention_pkg::CM_LINK));
		apb(1'b0, 8'h28, 32'h0);
		`CHK("slverr", 1'b1, err)
		close_out();
	end
endmodule

// file: dv/servo_ctrl_model.sv
`timescale 1ns/1ps
// Outer controller: drives servo-on and the drive reset.
module servo_ctrl_model (
	input  wire logic clock_i,
	input  wire logic run_i,
	input  wire logic stopped_i,
	input  wire logic rst_req_i,
	input  wire logic rst_force_i,
	input  wire logic ee_busy_i,
	output logic      servo_on_o,
	output logic      rst_o
);
	// Servo-on is only dropped once the motor has stopped.
	always_ff @(posedge clock_i) begin
		servo_on_o <= run_i | (servo_on_o & ~stopped_i);
	end
	// A requested reset waits for a running store; a forced one models power loss.
	assign rst_o = rst_force_i | (rst_req_i & ~ee_busy_i);
endmodule
